// File: arw_pkg.sv
// Constants of the converter's upper register bank.
// Assumes APB byte addresses equal to four times the register index.
package arw_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int IDX_W  = 6;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_WIN_MODE  = 6'h04;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN    = 6'h0C;
    localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS = 6'h0D;
    localparam logic [IDX_W-1:0] IDX_DBG       = 6'h0E;
    localparam logic [IDX_W-1:0] IDX_TEMP      = 6'h0F;
    localparam logic [IDX_W-1:0] IDX_OUT_L     = 6'h10;
    localparam logic [IDX_W-1:0] IDX_OUT_H     = 6'h11;
    localparam logic [IDX_W-1:0] IDX_WLT_L     = 6'h12;
    localparam logic [IDX_W-1:0] IDX_WLT_H     = 6'h13;
    localparam logic [IDX_W-1:0] IDX_WHT_L     = 6'h14;
    localparam logic [IDX_W-1:0] IDX_WHT_H     = 6'h15;

    // Field positions
    localparam int BIT_CONV_COMPLETE = 0;
    localparam int BIT_WINDOW_MATCH  = 1;
    localparam int BIT_DEBUG_RUN     = 0;
    localparam int MODE_W            = 3;

    // Implemented bits of the interrupt pair
    localparam logic [7:0] IRQ_BITS = 8'h03;

    // Reset values
    localparam logic [7:0]        RST_BYTE = 8'h00;
    localparam logic [15:0]       RST_WORD = 16'h0000;
    localparam logic [MODE_W-1:0] RST_MODE = 3'h0;

    // Window comparator conditions
    typedef enum logic [MODE_W-1:0] {
        ARW_WIN_NONE    = 3'h0,
        ARW_WIN_BELOW   = 3'h1,
        ARW_WIN_ABOVE   = 3'h2,
        ARW_WIN_INSIDE  = 3'h3,
        ARW_WIN_OUTSIDE = 3'h4
    } arw_win_mode_e;

endpackage

// File: arw_win_cmp.sv
// Window comparator of the converter's outcome against two thresholds.
// Assumes unsigned values in the same alignment as the outcome.
`timescale 1ns/10ps
module arw_win_cmp #(
    parameter int DATA_W = 16
) (
    input  wire logic [2:0]        i_mode,
    input  wire logic [DATA_W-1:0] i_value,
    input  wire logic [DATA_W-1:0] i_low,
    input  wire logic [DATA_W-1:0] i_high,
    output logic                   o_match
);

    logic below;
    logic above;

    assign below = i_value < i_low;
    assign above = i_value > i_high;

    always_comb begin
        unique case (i_mode)
            arw_pkg::ARW_WIN_NONE:    o_match = 1'b0;
            arw_pkg::ARW_WIN_BELOW:   o_match = below;
            arw_pkg::ARW_WIN_ABOVE:   o_match = above;
            arw_pkg::ARW_WIN_INSIDE:  o_match = !below && !above;
            arw_pkg::ARW_WIN_OUTSIDE: o_match = below || above;
            default:                  o_match = 1'b0;
        endcase
    end

endmodule // arw_win_cmp

// File: arw_regs.sv
// Upper register bank of the converter: interrupts, debug, result, window.
// Assumes an APB master on i_clk and a conversion engine on the same clock.
//
// Local design decision: the APB register port.
`timescale 1ns/10ps

module arw_regs #(
    parameter int DATA_W = 16
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_nrst,
    input  wire logic                      i_psel,
    input  wire logic                      i_penable,
    input  wire logic                      i_pwrite,
    input  wire logic [arw_pkg::ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]               i_pwdata,
    output logic      [31:0]               o_prdata,
    output logic                           o_pready,
    output logic                           o_pslverr,
    input  wire logic                      i_conv_done,
    input  wire logic [DATA_W-1:0]         i_conv_result,
    input  wire logic                      i_cpu_halted,
    output logic                           o_conv_run,
    output logic      [2:0]                o_window_mode,
    output logic                           o_irq
);

    logic [arw_pkg::IDX_W-1:0] idx;
    logic                      mapped;
    logic                      setup;
    logic                      access;
    logic                      wr_fire;
    logic                      rd_fire;
    logic [7:0]                wbyte;
    logic [7:0]                rd_byte;
    logic [7:0]                rd_hi;
    logic                      match;
    logic                      rd_outcome;
    logic [1:0]                set_flags;
    logic [1:0]                clr_flags;

    logic [7:0]        irq_enable_reg;
    logic [1:0]        irq_flags_reg;
    logic              debug_run_reg;
    logic [7:0]        temp_reg;
    logic [DATA_W-1:0] outcome_reg;
    logic [DATA_W-1:0] win_low_reg;
    logic [DATA_W-1:0] win_high_reg;
    logic [2:0]        win_mode_reg;
    logic [7:0]        snap_hi_reg;
    logic [31:0]       prdata_reg;
    logic              pslverr_reg;

    // Decode helpers
    function automatic logic is_mapped(input logic [5:0] a);
        unique case (a)
            arw_pkg::IDX_WIN_MODE, arw_pkg::IDX_IRQ_EN,
            arw_pkg::IDX_IRQ_FLAGS, arw_pkg::IDX_DBG,
            arw_pkg::IDX_TEMP, arw_pkg::IDX_OUT_L,
            arw_pkg::IDX_OUT_H, arw_pkg::IDX_WLT_L,
            arw_pkg::IDX_WLT_H, arw_pkg::IDX_WHT_L,
            arw_pkg::IDX_WHT_H: is_mapped = 1'b1;
            default:            is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic is_hit(input logic fire,
                                    input logic [5:0] a,
                                    input logic [5:0] target);
        is_hit = fire && (a == target);
    endfunction

    assign idx     = i_paddr[arw_pkg::ADDR_W-1:2];
    assign mapped  = is_mapped(idx) && (i_paddr[1:0] == 2'h0);
    assign setup   = i_psel && !i_penable;
    assign access  = i_psel && i_penable;
    assign wr_fire = access && i_pwrite && mapped;
    assign rd_fire = access && !i_pwrite && mapped;
    assign wbyte   = i_pwdata[7:0];

    // Zero wait states; data was taken in the setup cycle
    assign o_pready  = 1'b1;
    assign o_prdata  = prdata_reg;
    assign o_pslverr = pslverr_reg;

    // Read multiplexer
    always_comb begin
        rd_byte = arw_pkg::RST_BYTE;
        rd_hi   = arw_pkg::RST_BYTE;
        unique case (idx)
            arw_pkg::IDX_WIN_MODE:  rd_byte = {5'h00, win_mode_reg};
            arw_pkg::IDX_IRQ_EN:    rd_byte = irq_enable_reg;
            arw_pkg::IDX_IRQ_FLAGS: rd_byte = {6'h00, irq_flags_reg};
            arw_pkg::IDX_DBG:       rd_byte = {7'h00, debug_run_reg};
            arw_pkg::IDX_TEMP:      rd_byte = temp_reg;
            arw_pkg::IDX_OUT_L: begin
                rd_byte = outcome_reg[7:0];
                rd_hi   = outcome_reg[15:8];
            end
            arw_pkg::IDX_WLT_L: begin
                rd_byte = win_low_reg[7:0];
                rd_hi   = win_low_reg[15:8];
            end
            arw_pkg::IDX_WHT_L: begin
                rd_byte = win_high_reg[7:0];
                rd_hi   = win_high_reg[15:8];
            end
            arw_pkg::IDX_OUT_H, arw_pkg::IDX_WLT_H,
            arw_pkg::IDX_WHT_H: rd_byte = temp_reg;
            default:            rd_byte = arw_pkg::RST_BYTE;
        endcase
    end

    // Bus answer captured in setup
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            snap_hi_reg <= arw_pkg::RST_BYTE;
        end else if (setup) begin
            prdata_reg  <= {24'h00_0000, rd_byte};
            pslverr_reg <= !mapped;
            snap_hi_reg <= rd_hi;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_enable_reg <= arw_pkg::RST_BYTE;
        end else if (is_hit(wr_fire, idx, arw_pkg::IDX_IRQ_EN)) begin
            irq_enable_reg <= wbyte & arw_pkg::IRQ_BITS;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            win_mode_reg <= arw_pkg::RST_MODE;
        end else if (is_hit(wr_fire, idx, arw_pkg::IDX_WIN_MODE)) begin
            win_mode_reg <= wbyte[2:0];
        end
    end
    assign o_window_mode = win_mode_reg;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            debug_run_reg <= 1'b0;
        end else if (is_hit(wr_fire, idx, arw_pkg::IDX_DBG)) begin
            debug_run_reg <= wbyte[arw_pkg::BIT_DEBUG_RUN];
        end
    end
    assign o_conv_run = !i_cpu_halted || debug_run_reg;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            temp_reg <= arw_pkg::RST_BYTE;
        end else if (is_hit(wr_fire, idx, arw_pkg::IDX_TEMP)
                     || is_hit(wr_fire, idx, arw_pkg::IDX_WLT_L)
                     || is_hit(wr_fire, idx, arw_pkg::IDX_WHT_L)) begin
            temp_reg <= wbyte;
        end else if (is_hit(rd_fire, idx, arw_pkg::IDX_OUT_L)
                     || is_hit(rd_fire, idx, arw_pkg::IDX_WLT_L)
                     || is_hit(rd_fire, idx, arw_pkg::IDX_WHT_L)) begin
            temp_reg <= snap_hi_reg;
        end
    end

    // low threshold, committed by high byte
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            win_low_reg <= arw_pkg::RST_WORD;
        end else if (is_hit(wr_fire, idx, arw_pkg::IDX_WLT_H)) begin
            win_low_reg <= {wbyte, temp_reg};
        end
    end

    // high threshold, committed by high byte
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            win_high_reg <= arw_pkg::RST_WORD;
        end else if (is_hit(wr_fire, idx, arw_pkg::IDX_WHT_H)) begin
            win_high_reg <= {wbyte, temp_reg};
        end
    end

    // outcome latched at end of conversion
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            outcome_reg <= arw_pkg::RST_WORD;
        end else if (i_conv_done) begin
            outcome_reg <= i_conv_result;
        end
    end

    arw_win_cmp #(
        .DATA_W (DATA_W)
    ) u_win_cmp (
        .i_mode  (win_mode_reg),
        .i_value (i_conv_result),
        .i_low   (win_low_reg),
        .i_high  (win_high_reg),
        .o_match (match)
    );

    assign rd_outcome = is_hit(rd_fire, idx, arw_pkg::IDX_OUT_L)
                        || is_hit(rd_fire, idx, arw_pkg::IDX_OUT_H);

    assign set_flags[arw_pkg::BIT_CONV_COMPLETE] = i_conv_done;
    assign set_flags[arw_pkg::BIT_WINDOW_MATCH]  = i_conv_done && match;

    // clear by one or outcome read
    assign clr_flags = rd_outcome ? 2'h3
                     : (is_hit(wr_fire, idx, arw_pkg::IDX_IRQ_FLAGS)
                        ? wbyte[1:0] : 2'h0);

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_flags_reg <= 2'h0;
        end else begin
            irq_flags_reg <= (irq_flags_reg & ~clr_flags) | set_flags;
        end
    end

    assign o_irq = |(irq_flags_reg & irq_enable_reg[1:0]);

    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_en_window;
        is_hit(wr_fire, idx, arw_pkg::IDX_IRQ_EN) && i_pwdata[1];
    endsequence

    sequence s_read_low;
        setup && !i_pwrite && idx == arw_pkg::IDX_OUT_L
            && i_paddr[1:0] == 2'h0 ##1 access;
    endsequence

    property p_en_window;
        s_en_window ##1 irq_flags_reg[1] |-> o_irq;
    endproperty
    a_en_window: assert property (p_en_window)
        else $error("window flag enabled but no interrupt");

    property p_en_done;
        irq_enable_reg[0] == 1'b0 && irq_flags_reg == 2'h1 |-> !o_irq;
    endproperty
    a_en_done: assert property (p_en_done)
        else $error("disabled completion flag raised interrupt");

    property p_match_set;
        i_conv_done && match |=> irq_flags_reg[1];
    endproperty
    a_match_set: assert property (p_match_set)
        else $error("window flag not set on match");

    property p_match_cause;
        $rose(irq_flags_reg[1]) |-> $past(i_conv_done) && $past(match);
    endproperty
    a_match_cause: assert property (p_match_cause)
        else $error("window flag set without a matching result");

    property p_zero_keeps;
        is_hit(wr_fire, idx, arw_pkg::IDX_IRQ_FLAGS) && !i_pwdata[1]
            && irq_flags_reg[1] |=> irq_flags_reg[1];
    endproperty
    a_zero_keeps: assert property (p_zero_keeps)
        else $error("writing zero cleared the window flag");

    property p_done_set;
        i_conv_done |=> irq_flags_reg[0] ##0 outcome_reg == $past(i_conv_result);
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("completion flag or outcome not updated");

    property p_read_clears;
        rd_outcome && !i_conv_done |=> irq_flags_reg == 2'h0;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("outcome read did not clear flags");

    property p_halt;
        i_cpu_halted && !debug_run_reg |-> !o_conv_run;
    endproperty
    a_halt: assert property (p_halt)
        else $error("converter runs while halted without debug run");

    property p_latch_high;
        s_read_low |=> temp_reg == $past(outcome_reg[15:8], 2);
    endproperty
    a_latch_high: assert property (p_latch_high)
        else $error("latch missed the outcome high byte");

    property p_low_commit;
        is_hit(wr_fire, idx, arw_pkg::IDX_WLT_H)
            |=> win_low_reg == {$past(wbyte), $past(temp_reg)};
    endproperty
    a_low_commit: assert property (p_low_commit)
        else $error("low threshold not committed from latch");

    property p_high_commit;
        is_hit(wr_fire, idx, arw_pkg::IDX_WHT_H)
            |=> win_high_reg == {$past(wbyte), $past(temp_reg)};
    endproperty
    a_high_commit: assert property (p_high_commit)
        else $error("high threshold not committed from latch");

    property p_out_ro;
        wr_fire && !i_conv_done |=> $stable(outcome_reg);
    endproperty
    a_out_ro: assert property (p_out_ro)
        else $error("bus write changed the outcome");

    property p_no_window;
        i_conv_done && !irq_flags_reg[1]
            && (win_mode_reg == arw_pkg::ARW_WIN_NONE
                || win_mode_reg > arw_pkg::ARW_WIN_OUTSIDE)
            |=> !irq_flags_reg[1];
    endproperty
    a_no_window: assert property (p_no_window)
        else $error("window flag set with comparator off");

    property p_irq_drop;
        (irq_flags_reg & irq_enable_reg[1:0]) == 2'h0 |-> !o_irq;
    endproperty
    a_irq_drop: assert property (p_irq_drop)
        else $error("interrupt high with no enabled flag");

endmodule // arw_regs

// File: arw_conv_model.sv
// Behavioural conversion engine on the far side of the register bank.
// Assumes the bank's clock; converts only while the run output is high.
`timescale 1ns/10ps
module arw_conv_model #(
    parameter int CONV_CYC = 3
) (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_run,
    input  wire logic        i_start,
    input  wire logic [15:0] i_value,
    output logic             o_done,
    output logic      [15:0] o_result
);
    int          cnt;
    logic [15:0] val;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt      <= 0;
            val      <= 16'h0000;
            o_done   <= 1'h0;
            o_result <= 16'h0000;
        end else begin
            o_done   <= 1'h0;
            o_result <= ~o_result;
            if (cnt == 0 && i_start) begin
                cnt <= CONV_CYC;
                val <= i_value;
            end else if (cnt != 0 && i_run) begin
                cnt <= cnt - 1;
                if (cnt == 1) begin
                    o_done   <= 1'h1;
                    o_result <= val;
                end
            end
        end
    end
endmodule // arw_conv_model

// File: test_adc_result_window_irq_regs.sv
// Self-checking bench of the converter's upper register bank.
// Assumes an APB master here and the conversion engine model.
`timescale 1ns/10ps
module test_adc_result_window_irq_regs;
    localparam logic [15:0] LO = 16'h10A5;
    localparam logic [15:0] HI = 16'h205A;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        done, halted, run, irq, start, err;
    logic [15:0] result, sval;
    logic [2:0]  wmode;
    int          mismatches, cmp_count, cycles;

    arw_regs #(.DATA_W(16)) dut_u (
        .i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_conv_done(done), .i_conv_result(result), .i_cpu_halted(halted),
        .o_conv_run(run), .o_window_mode(wmode), .o_irq(irq));
    arw_conv_model #(.CONV_CYC(3)) model_u (
        .i_clk(clk), .i_nrst(nrst), .i_run(run), .i_start(start),
        .i_value(sval), .o_done(done), .o_result(result));

    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    task automatic results();
        if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdc(input string n, input logic [7:0] a,
                       input logic [7:0] e);
        apb(1'h0, a, 8'h00);
        chk(n, {24'h000000, e}, rd);
    endtask
    task automatic go(input logic [15:0] v);
        start <= 1'h1;
        sval  <= v;
        @(posedge clk);
        start <= 1'h0;
    endtask
    task automatic wt(input logic e);
        int n;
        n = 0;
        while (done !== 1'h1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk("done", 32'(e), 32'(done));
        repeat (2) @(posedge clk);
    endtask
    function automatic logic mt(input logic [2:0] m, input logic [15:0] v);
        case (m)
            3'h1: return v < LO;
            3'h2: return v > HI;
            3'h3: return v >= LO && v <= HI;
            3'h4: return v < LO || v > HI;
            default: return 1'h0;
        endcase
    endfunction

    task automatic t_reset();
        logic [7:0] a[11] = '{8'h10, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40,
                              8'h44, 8'h48, 8'h4C, 8'h50, 8'h54};
        chk("irq", 32'h0, 32'(irq));
        for (int i = 0; i < 11; i++) rdc("reset", a[i], 8'h00);
    endtask
    task automatic t_access();
        wr(8'h30, 8'hFF);
        rdc("enable", 8'h30, 8'h03);
        wr(8'h38, 8'hFF);
        rdc("debug", 8'h38, 8'h01);
        wr(8'h3C, 8'hA5);
        rdc("latch", 8'h3C, 8'hA5);
        chk("slverr_ok", 32'h0, 32'(err));
        wr(8'h48, LO[7:0]);
        wr(8'h4C, LO[15:8]);
        wr(8'h50, HI[7:0]);
        wr(8'h54, HI[15:8]);
        rdc("low_l", 8'h48, LO[7:0]);
        rdc("low_h", 8'h4C, LO[15:8]);
        rdc("high_l", 8'h50, HI[7:0]);
        rdc("latch", 8'h3C, HI[15:8]);
        rdc("high_h", 8'h54, HI[15:8]);
        wr(8'h40, 8'hFF);
        rdc("outcome", 8'h40, 8'h00);
        apb(1'h0, 8'hFC, 8'h00);
        chk("slverr", 32'h1, 32'(err));
        wr(8'h30, 8'h00);
        wr(8'h38, 8'h00);
    endtask
    task automatic t_window();
        logic [15:0] v[4] = '{LO - 16'h0001, LO, HI, HI + 16'h0001};
        for (int m = 0; m < 6; m++) begin
            wr(8'h10, 8'(m));
            chk("mode", 32'(m), 32'(wmode));
            for (int i = 0; i < 4; i++) begin
                go(v[i]);
                wt(1'h1);
                rdc("flags", 8'h34, {6'h00, mt(3'(m), v[i]), 1'h1});
                rdc("out_l", 8'h40, v[i][7:0]);
                rdc("out_h", 8'h44, v[i][15:8]);
                rdc("cleared", 8'h34, 8'h00);
            end
        end
    endtask
    task automatic t_w1c();
        wr(8'h10, 8'h03);
        go(16'h1800);
        wt(1'h1);
        wr(8'h34, 8'h00);
        rdc("w0", 8'h34, 8'h03);
        wr(8'h34, 8'h02);
        rdc("w1_win", 8'h34, 8'h01);
        wr(8'h34, 8'h01);
        rdc("w1_cc", 8'h34, 8'h00);
    endtask
    task automatic t_irq();
        wr(8'h30, 8'h01);
        wr(8'h10, 8'h01);
        go(16'h0800);
        wt(1'h1);
        chk("irq_cc", 32'h1, 32'(irq));
        wr(8'h34, 8'h01);
        chk("irq_mask", 32'h0, 32'(irq));
        wr(8'h30, 8'h02);
        chk("irq_win", 32'h1, 32'(irq));
        wr(8'h34, 8'h02);
        chk("irq_drop", 32'h0, 32'(irq));
        wr(8'h30, 8'h00);
    endtask
    task automatic t_debug();
        wr(8'h10, 8'h00);
        halted <= 1'h1;
        @(posedge clk);
        @(posedge clk);
        chk("run_halt", 32'h0, 32'(run));
        go(16'h0123);
        wt(1'h0);
        rdc("no_flag", 8'h34, 8'h00);
        wr(8'h38, 8'h01);
        chk("run_dbg", 32'h1, 32'(run));
        wt(1'h1);
        rdc("flag", 8'h34, 8'h01);
        halted <= 1'h0;
        wr(8'h38, 8'h00);
        chk("run_free", 32'h1, 32'(run));
    endtask
    task automatic t_rerun();
        wr(8'h30, 8'h03);
        go(16'h1234);
        wt(1'h1);
        nrst <= 1'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        chk("irq_rst", 32'h0, 32'(irq));
        rdc("en_rst", 8'h30, 8'h00);
        rdc("flags_rst", 8'h34, 8'h00);
        rdc("out_rst", 8'h40, 8'h00);
    endtask

    initial begin
        {nrst, psel, penable, pwrite, halted, start} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        sval = 16'h0000;
        repeat (6) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        t_reset();
        t_access();
        t_window();
        t_w1c();
        t_irq();
        t_debug();
        t_rerun();
        results();
    end
endmodule // test_adc_result_window_irq_regs
